// *** shared/gcm_map.vh ***
// constants for the gpio clock mask and live insertion block
`ifndef GCM_MAP_VH
`define GCM_MAP_VH
// ---------------------------------------------
// configuration space byte addresses
// ---------------------------------------------
`define GCM_OFF_CMD 8'h04
`define GCM_OFF_BRCTL 8'h3C
`define GCM_OFF_CHIP 8'h40
`define GCM_OFF_GPIO 8'h64
`define GCM_OFF_GPIN 8'h68
`define GCM_OFF_SCLK 8'h6C
// ---------------------------------------------
// field positions
// ---------------------------------------------
`define GCM_CMD_IO 0
`define GCM_CMD_MEM 1
`define GCM_CMD_MASTER 2
`define GCM_BRCTL_SRST 22
`define GCM_CHIP_LIVE 0
`define GCM_PIN_SCLK 0
`define GCM_PIN_LOAD 2
`define GCM_PIN_LIVE 3
// ---------------------------------------------
// reset values
// ---------------------------------------------
`define GCM_RST_OUT 4'h0
`define GCM_RST_OE 4'h0
`define GCM_RST_MASK 16'h0000
`define GCM_RST_CMD 3'h0
// ---------------------------------------------
// timing
// ---------------------------------------------
`define GCM_SYS_MHZ 125
`define GCM_SCLK_MAX_MHZ 33
`define GCM_SCLK_DIV_MIN ((`GCM_SYS_MHZ + `GCM_SCLK_MAX_MHZ - 1) / `GCM_SCLK_MAX_MHZ)
`define GCM_SCLK_DIV (2 * `GCM_SCLK_DIV_MIN)
`define GCM_SEQ_PERIODS 23
`define GCM_MASK_BITS 16
`define GCM_FIFO_DEPTH 32
`endif

// *** rtl/gcm_gpio.v ***
// gpio port with serial clock mask loader and live insertion halt
// Overview of operation
// - oe set bit drives matching pin
// - oe clear bit tristates pin
// - zero bits in set/clear change nothing
// - reset leaves all pins input only
// - reset clears stored output data
// - input field shows live pin levels
// - data set drives high, clear low
// - stored value driven only when enabled
// - fields reached by type 0 config cycles
// - start mask shift after primary reset release
// - hold secondary reset through 23-cycle shift
// - pin 0 shift clock, max 33MHz
// - pin 2 low load, then high shift
// - mask arrives msb first, lsb last
// - slot clock runs if either pair bit 0
// - bits 12:8 gate clocks 8:4, 0 enables
// - bit 13 gates clock 9, 14-15 reserved
// - all-ones mask holds clocks high
// - after shift: tristate, ignore input, release reset
// - config writes update clock mask
// - live mode needs bit set, pin 3 input
// - pin 3 high masks io/mem/master enables
// - halted: drain queues, accept config cycles
`timescale 1ns/10ps
`include "gcm_map.vh"

// ---------------------------------------------
// small fifo, width and depth as parameters
// ---------------------------------------------
module gcm_fifo #(
  parameter W = 1,
  parameter D = 32,
  parameter AW = 5
) (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // fill side
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [W-1:0] in_data_i,
  // drain side
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [W-1:0] out_data_o
);
  reg [W-1:0] mem_r [0:D-1]; // storage
  reg [AW-1:0] wp_r; // write pointer
  reg [AW-1:0] rp_r; // read pointer
  reg [AW:0] cnt_r; // fill level
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (cnt_r != D[AW:0]); // full stalls the source
  assign out_valid_o = (cnt_r != {(AW+1){1'b0}}); // valid when not empty
  assign out_data_o = mem_r[rp_r];

  // pointer and level update
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      wp_r <= {AW{1'b0}};
      rp_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wp_r <= wp_r + 1'b1;
      end
      if (pop) begin
        rp_r <= rp_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end

  // storage write, no reset needed
  always @(posedge clk_sys_i) begin
    if (push) begin
      mem_r[wp_r] <= in_data_i;
    end
  end
endmodule // gcm_fifo

// ---------------------------------------------
// top: gpio, clock mask loader, live insertion
// ---------------------------------------------
module gcm_gpio (
  // clock and reset (primary reset)
  input wire clk_sys_i,
  input wire rst_n_i,
  // configuration access
  input wire cfg_wr_i,
  input wire cfg_rd_i,
  input wire [7:0] cfg_addr_i,
  input wire [3:0] cfg_be_i,
  input wire [31:0] cfg_wdata_i,
  output reg [31:0] cfg_rdata_o,
  output reg cfg_ack_o,
  // gpio pins
  input wire [3:0] gpio_i,
  output reg [3:0] gpio_o,
  output reg [3:0] gpio_oe_n_o,
  // serial mask input pin
  input wire clock_mask_serial_in_i,
  // secondary side
  output reg secondary_reset_n_o,
  output reg [9:0] secondary_clock_out_o,
  // internal enables toward the bridge core
  output reg io_en_o,
  output reg mem_en_o,
  output reg master_en_o,
  output reg forward_halt_o
);
  // ---------------------------------------------
  // state codes and local constants
  // ---------------------------------------------
  localparam [1:0] ST_IDLE = 2'b00; // waiting to start
  localparam [1:0] ST_RUN = 2'b01; // load and shift periods
  localparam [1:0] ST_DRAIN = 2'b10; // empty the fifo
  localparam [1:0] ST_DONE = 2'b11; // normal gpio operation
  localparam integer DIV_I = `GCM_SCLK_DIV; // sys cycles per shift clock
  localparam integer PER_I = `GCM_SEQ_PERIODS; // shift clock periods
  localparam integer BITS_I = `GCM_MASK_BITS; // mask length
  localparam [3:0] DIV_LAST = DIV_I[3:0] - 4'd1;
  localparam [3:0] DIV_HALF = DIV_I[4:1];
  localparam [3:0] SAMPLE_PH = DIV_HALF - 4'd1;
  localparam [4:0] PER_LAST = PER_I[4:0] - 5'd1;
  localparam [4:0] BIT_LAST = BITS_I[4:0];

  // ---------------------------------------------
  // registers
  // ---------------------------------------------
  reg [3:0] out_r; // stored output data
  reg [3:0] oe_r; // output enables
  reg [2:0] cmd_r; // io, mem, master enables as written
  reg srst_bit_r; // secondary reset bit
  reg live_bit_r; // live insertion mode bit
  reg [15:0] clk_mask_r; // clock disable mask
  reg [15:0] shift_r; // mask being assembled
  reg [1:0] st_r; // sequencer state
  reg [3:0] ph_r; // phase within shift clock period
  reg [4:0] per_r; // shift clock period index
  reg [11:0] gs1_r, gs2_r, gs3_r; // gpio sync stages
  reg [3:0] gpin_r; // filtered gpio levels
  reg ms1_r, ms2_r, ms3_r; // serial input sync stages
  reg msk_r; // filtered serial input
  reg tog_r; // secondary clock source

  // ---------------------------------------------
  // decode and helpers
  // ---------------------------------------------
  wire [31:0] bmask = {{8{cfg_be_i[3]}}, {8{cfg_be_i[2]}}, {8{cfg_be_i[1]}}, {8{cfg_be_i[0]}}};
  wire [31:0] wd = cfg_wdata_i & bmask; // disabled lanes write zero
  wire wr_cmd = cfg_wr_i && (cfg_addr_i == `GCM_OFF_CMD);
  wire wr_brctl = cfg_wr_i && (cfg_addr_i == `GCM_OFF_BRCTL);
  wire wr_chip = cfg_wr_i && (cfg_addr_i == `GCM_OFF_CHIP);
  wire wr_gpio = cfg_wr_i && (cfg_addr_i == `GCM_OFF_GPIO);
  wire wr_sclk = cfg_wr_i && (cfg_addr_i == `GCM_OFF_SCLK);
  wire shifting = (st_r != ST_DONE);
  wire sample = (st_r == ST_RUN) && (ph_r == SAMPLE_PH) && (per_r != 5'd0) && (per_r <= BIT_LAST);
  wire f_in_ready, f_out_valid, f_out_data;
  wire stall = sample && !f_in_ready; // fifo full holds the sequencer
  wire f_pop = f_out_valid && !wr_sclk; // software write to the mask wins
  wire live_mode = live_bit_r && !oe_r[`GCM_PIN_LIVE];
  wire halt = live_mode && gpin_r[`GCM_PIN_LIVE];
  wire [9:0] clk_en;

  // ---------------------------------------------
  // bit fifo between sampler and mask
  // ---------------------------------------------
  gcm_fifo #(
    .W(1),
    .D(`GCM_FIFO_DEPTH),
    .AW(5)
  ) u_fifo (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(sample),
    .in_ready_o(f_in_ready),
    .in_data_i(msk_r),
    .out_valid_o(f_out_valid),
    .out_ready_i(!wr_sclk),
    .out_data_o(f_out_data)
  );

  // ---------------------------------------------
  // pin synchronisers, three stages, 2+3 agree
  // ---------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gs1_r <= 12'h000;
      gs2_r <= 12'h000;
      gs3_r <= 12'h000;
      gpin_r <= 4'h0;
      ms1_r <= 1'b0;
      ms2_r <= 1'b0;
      ms3_r <= 1'b0;
      msk_r <= 1'b0;
    end else begin
      gs1_r <= {8'h00, gpio_i};
      gs2_r <= gs1_r;
      gs3_r <= gs2_r;
      ms1_r <= clock_mask_serial_in_i;
      ms2_r <= ms1_r;
      ms3_r <= ms2_r;
      // per bit: accept only when stages two and three agree
      gpin_r <= (gs2_r[3:0] & gs3_r[3:0]) | (gpin_r & (gs2_r[3:0] | gs3_r[3:0]));
      if (ms2_r == ms3_r) begin
        msk_r <= ms3_r;
      end
    end
  end

  // ---------------------------------------------
  // configuration registers
  // ---------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      out_r <= `GCM_RST_OUT;
      oe_r <= `GCM_RST_OE;
      cmd_r <= `GCM_RST_CMD;
      srst_bit_r <= 1'b0;
      live_bit_r <= 1'b0;
    end else begin
      // write-one fields, zeros leave state alone
      if (wr_gpio) begin
        out_r <= (out_r | wd[3:0]) & ~wd[11:8];
        oe_r <= (oe_r | wd[19:16]) & ~wd[27:24];
      end
      // stored enables stay readable while masked
      if (wr_cmd && cfg_be_i[0]) begin
        cmd_r <= cfg_wdata_i[2:0];
      end
      if (wr_brctl && cfg_be_i[2]) begin
        srst_bit_r <= cfg_wdata_i[`GCM_BRCTL_SRST];
      end
      if (wr_chip && cfg_be_i[0]) begin
        live_bit_r <= cfg_wdata_i[`GCM_CHIP_LIVE];
      end
    end
  end

  // ---------------------------------------------
  // configuration read path and ack
  // ---------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o <= 32'h00000000;
      cfg_ack_o <= 1'b0;
    end else begin
      cfg_ack_o <= cfg_wr_i || cfg_rd_i;
      if (cfg_rd_i) begin
        if (cfg_addr_i == `GCM_OFF_CMD) begin
          cfg_rdata_o <= {29'h0, cmd_r};
        end else if (cfg_addr_i == `GCM_OFF_BRCTL) begin
          cfg_rdata_o <= {9'h0, srst_bit_r, 22'h0};
        end else if (cfg_addr_i == `GCM_OFF_CHIP) begin
          cfg_rdata_o <= {31'h0, live_bit_r};
        end else if (cfg_addr_i == `GCM_OFF_GPIO) begin
          cfg_rdata_o <= {4'h0, oe_r, 4'h0, oe_r, 4'h0, out_r, 4'h0, out_r};
        end else if (cfg_addr_i == `GCM_OFF_GPIN) begin
          cfg_rdata_o <= {28'h0, gpin_r};
        end else if (cfg_addr_i == `GCM_OFF_SCLK) begin
          cfg_rdata_o <= {16'h0, clk_mask_r};
        end else begin
          cfg_rdata_o <= 32'h00000000; // unmapped reads zero
        end
      end
    end
  end

  // ---------------------------------------------
  // mask load sequencer
  // ---------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_r <= ST_IDLE;
      ph_r <= 4'h0;
      per_r <= 5'd0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          // primary reset gone, secondary still held
          st_r <= ST_RUN;
          ph_r <= 4'h0;
          per_r <= 5'd0;
        end
        ST_RUN: begin
          if (!stall) begin
            if (ph_r == DIV_LAST) begin
              ph_r <= 4'h0;
              if (per_r == PER_LAST) begin
                st_r <= ST_DRAIN;
              end else begin
                per_r <= per_r + 5'd1;
              end
            end else begin
              ph_r <= ph_r + 4'h1;
            end
          end
        end
        ST_DRAIN: begin
          if (!f_out_valid) begin
            st_r <= ST_DONE;
          end
        end
        default: begin
          st_r <= ST_DONE;
        end
      endcase
    end
  end

  // ---------------------------------------------
  // mask assembly and clock mask register
  // ---------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      shift_r <= 16'h0000;
      clk_mask_r <= `GCM_RST_MASK;
    end else begin
      if (f_pop) begin
        shift_r <= {shift_r[14:0], f_out_data};
      end
      if (wr_sclk) begin
        clk_mask_r <= (clk_mask_r & ~bmask[15:0]) | wd[15:0];
      end else if (st_r == ST_DRAIN && !f_out_valid) begin
        clk_mask_r <= shift_r;
      end
    end
  end

  // ---------------------------------------------
  // clock enables from the mask
  // ---------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_slot
      assign clk_en[gi] = ~(clk_mask_r[2*gi] & clk_mask_r[2*gi+1]);
    end
  endgenerate
  assign clk_en[8:4] = ~clk_mask_r[12:8];
  assign clk_en[9] = ~clk_mask_r[13];

  // ---------------------------------------------
  // secondary clocks, disabled ones held high
  // ---------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tog_r <= 1'b0;
      secondary_clock_out_o <= 10'h3FF;
    end else begin
      tog_r <= ~tog_r;
      secondary_clock_out_o <= {10{tog_r}} | ~clk_en;
    end
  end

  // ---------------------------------------------
  // pin drive and secondary reset
  // ---------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      gpio_o <= 4'h0;
      gpio_oe_n_o <= 4'hF;
      secondary_reset_n_o <= 1'b0;
    end else if (shifting) begin
      // shift clock on pin 0, load/shift on pin 2
      gpio_o[`GCM_PIN_SCLK] <= (st_r == ST_RUN) && (ph_r >= DIV_HALF);
      gpio_o[`GCM_PIN_LOAD] <= (per_r != 5'd0);
      gpio_o[1] <= 1'b0;
      gpio_o[3] <= 1'b0;
      gpio_oe_n_o <= 4'hA; // pins 1 and 3 unused
      secondary_reset_n_o <= 1'b0;
    end else begin
      // back under register control
      gpio_o <= out_r;
      gpio_oe_n_o <= ~oe_r;
      secondary_reset_n_o <= !srst_bit_r;
    end
  end

  // ---------------------------------------------
  // live insertion masking of enables
  // ---------------------------------------------
  always @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      io_en_o <= 1'b0;
      mem_en_o <= 1'b0;
      master_en_o <= 1'b0;
      forward_halt_o <= 1'b0;
    end else begin
      io_en_o <= cmd_r[`GCM_CMD_IO] && !halt;
      mem_en_o <= cmd_r[`GCM_CMD_MEM] && !halt;
      master_en_o <= cmd_r[`GCM_CMD_MASTER] && !halt;
      forward_halt_o <= halt;
    end
  end
endmodule // gcm_gpio

// *** verif/gcm_gpio_sva.sv ***
// assertions for the gpio clock mask block
`timescale 1ns/10ps
module gcm_gpio_sva (
  // clock and reset
  input wire clk_sys_i,
  input wire rst_n_i,
  // config bus
  input wire cfg_wr_i,
  input wire cfg_rd_i,
  input wire [31:0] cfg_rdata_o,
  input wire cfg_ack_o,
  // pins and core side
  input wire [3:0] gpio_o,
  input wire [3:0] gpio_oe_n_o,
  input wire secondary_reset_n_o,
  input wire io_en_o,
  input wire mem_en_o,
  input wire master_en_o,
  input wire forward_halt_o
);
  // ---------------------------
  // cycles since reset release
  // ---------------------------
  reg [8:0] run_r; // saturating count
  always @(posedge clk_sys_i) begin
    if (!rst_n_i)
      run_r <= 9'h000;
    else if (run_r != 9'h1FF)
      run_r <= run_r + 9'h001;
  end
  wire shift_w = (run_r > 9'h008) && (run_r < 9'h0A8); // mid shift
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  // one shift clock period, high then low
  sequence s_sclk;
    gpio_o[0] [*4] ##1 !gpio_o[0] [*4];
  endsequence
  // load phase followed by shifting
  sequence s_load;
    !gpio_o[2] ##[1:12] gpio_o[2] [*8];
  endsequence
  a_ack_follow: assert property ((cfg_wr_i || cfg_rd_i) |=> cfg_ack_o)
    else $error("config access without ack");
  a_ack_cause: assert property (cfg_ack_o |-> $past(cfg_wr_i || cfg_rd_i))
    else $error("ack without access");
  a_rdata_hold: assert property (!$past(cfg_rd_i) |-> $stable(cfg_rdata_o))
    else $error("read data moved without read");
  a_srst_hold: assert property ((run_r < 9'h0B8) |-> !secondary_reset_n_o)
    else $error("secondary reset released early");
  a_shift_pins: assert property (shift_w |-> gpio_oe_n_o == 4'hA)
    else $error("wrong pin drive during shift");
  a_sclk_rate: assert property ((shift_w && $rose(gpio_o[0])) |-> s_sclk)
    else $error("shift clock period wrong");
  a_load_step: assert property ((run_r == 9'h001) |-> s_load)
    else $error("load then shift order wrong");
  a_halt_mask: assert property ((forward_halt_o && $past(forward_halt_o)) |->
    !(io_en_o || mem_en_o || master_en_o))
    else $error("enables not masked in halt");
  a_halt_input: assert property (forward_halt_o |-> gpio_oe_n_o[3])
    else $error("halt while pin 3 driven");
endmodule // gcm_gpio_sva

bind gcm_gpio gcm_gpio_sva u_sva (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i),
  .cfg_rd_i(cfg_rd_i), .cfg_rdata_o(cfg_rdata_o), .cfg_ack_o(cfg_ack_o), .gpio_o(gpio_o),
  .gpio_oe_n_o(gpio_oe_n_o), .secondary_reset_n_o(secondary_reset_n_o), .io_en_o(io_en_o),
  .mem_en_o(mem_en_o), .master_en_o(master_en_o), .forward_halt_o(forward_halt_o));

// *** verif/gcm_shreg_model.sv ***
// external parallel-load shift register model
`timescale 1ns/10ps
module gcm_shreg_model (
  // sampling clock
  input wire clk_sys_i,
  // control pins as seen on the wire
  input wire sclk_i,
  input wire load_n_i,
  input wire drv_i,
  // slot presence inputs
  input wire [15:0] presence_i,
  // serial output
  output wire serial_o
);
  reg [15:0] sr_r = 16'h0000; // shift stages
  reg sclk_r = 1'b0; // last shift clock level
  reg tog_r = 1'b0; // junk while undriven
  // load low loads, rising clock shifts
  always @(posedge clk_sys_i) begin
    sclk_r <= sclk_i;
    tog_r <= ~tog_r;
    if (drv_i && !load_n_i)
      sr_r <= presence_i;
    else if (drv_i && sclk_i && !sclk_r)
      sr_r <= {sr_r[14:0], tog_r};
  end
  // msb out first, garbage outside frames
  assign serial_o = drv_i ? sr_r[15] : tog_r;
endmodule // gcm_shreg_model

// *** verif/gcm_gpio_tb.sv ***
// self-checking bench for the gpio clock mask block
`timescale 1ns/10ps
module gcm_gpio_tb;
  // ---------------------------
  // signals
  // ---------------------------
  reg clk_sys_i = 1'b0;
  reg rst_n_i = 1'b0;
  reg cfg_wr_i = 1'b0;
  reg cfg_rd_i = 1'b0;
  reg [7:0] cfg_addr_i = 8'h00;
  reg [3:0] cfg_be_i = 4'hF;
  reg [31:0] cfg_wdata_i = 32'h00000000;
  wire [31:0] cfg_rdata_o;
  wire cfg_ack_o;
  wire [3:0] gpio_o;
  wire [3:0] gpio_oe_n_o;
  wire [3:0] pin_w; // resolved pin levels
  reg [3:0] ext_r = 4'h0; // far side pin drive
  wire ser_w;
  wire secondary_reset_n_o;
  wire [9:0] secondary_clock_out_o;
  wire io_en_o;
  wire mem_en_o;
  wire master_en_o;
  wire forward_halt_o;
  reg [15:0] pres_r = 16'h0000; // presence bits
  reg [31:0] seed_r = 32'hAFD88699;
  reg [32:0] exp_q[$]; // notes: read flag, data
  reg [32:0] note_r;
  reg [3:0] out_e = 4'h0; // expected out data
  reg [3:0] oe_e = 4'h0; // expected enables
  reg [31:0] wr_t [0:6] = '{32'h00000005, 32'h00030000, 32'h00000100, 32'h00000000,
    32'h01000000, 32'h000F020A, 32'h0F000000};
  int mismatches = 0;
  int check_count = 0;
  always #4 clk_sys_i = ~clk_sys_i;
  // wire level from all drivers
  assign pin_w = (~gpio_oe_n_o & gpio_o) | (gpio_oe_n_o & ext_r);
  gcm_gpio dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i),
    .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i), .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o),
    .cfg_ack_o(cfg_ack_o), .gpio_i(pin_w), .gpio_o(gpio_o), .gpio_oe_n_o(gpio_oe_n_o),
    .clock_mask_serial_in_i(ser_w), .secondary_reset_n_o(secondary_reset_n_o),
    .secondary_clock_out_o(secondary_clock_out_o), .io_en_o(io_en_o), .mem_en_o(mem_en_o),
    .master_en_o(master_en_o), .forward_halt_o(forward_halt_o));
  gcm_shreg_model u_sr (.clk_sys_i(clk_sys_i), .sclk_i(pin_w[0]), .load_n_i(pin_w[2]),
    .drv_i(!gpio_oe_n_o[0]), .presence_i(pres_r), .serial_o(ser_w));
  // ---------------------------
  // helpers
  // ---------------------------
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task check(input string name, input [31:0] seen, input [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h seen %h", name, exp, seen);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // one config access, strobe left up
  task acc(input bit rd, input [7:0] a, input [31:0] d);
    @(posedge clk_sys_i);
    cfg_wr_i <= !rd;
    cfg_rd_i <= rd;
    cfg_addr_i <= a;
    cfg_wdata_i <= d;
    exp_q.push_back({rd, d});
  endtask
  task idle;
    @(posedge clk_sys_i);
    cfg_wr_i <= 1'b0;
    cfg_rd_i <= 1'b0;
  endtask
  // bounded wait for all answers
  task drain;
    int n;
    n = 0;
    while (exp_q.size() != 0 && n < 20) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (exp_q.size() != 0) begin
      mismatches++;
      finish_test();
    end
  endtask
  // enabled clocks toggle, others stay high
  task clk_chk(input [15:0] m);
    reg [9:0] en;
    reg [9:0] c0;
    for (int i = 0; i < 4; i++)
      en[i] = !(m[2*i] & m[2*i+1]);
    en[8:4] = ~m[12:8];
    en[9] = !m[13];
    @(negedge clk_sys_i);
    c0 = secondary_clock_out_o;
    @(negedge clk_sys_i);
    check("clk_run", c0 ^ secondary_clock_out_o, en);
    check("clk_held", c0 | en, 32'h000003FF);
  endtask
  // reset, serial mask load, checks after
  task load_mask(input [15:0] m);
    int n;
    @(posedge clk_sys_i);
    pres_r <= m;
    rst_n_i <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    n = 0;
    while (secondary_reset_n_o !== 1'b1 && n < 400) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 400) begin
      mismatches++;
      finish_test();
    end
    check("srst_delay", n >= 184 && n <= 190, 1);
    repeat (3) @(negedge clk_sys_i);
    check("oe_after", gpio_oe_n_o, 4'hF);
    acc(1, 8'h6C, {16'h0000, m});
    acc(1, 8'h64, 32'h00000000);
    idle;
    drain;
    clk_chk(m);
    acc(1, 8'h6C, {16'h0000, m});
    idle;
    drain;
  endtask
  // ---------------------------
  // collects answers, compares notes
  // ---------------------------
  always @(negedge clk_sys_i) begin
    if (cfg_ack_o === 1'b1) begin
      if (exp_q.size() == 0)
        check("ack_extra", 1, 0);
      else begin
        note_r = exp_q.pop_front();
        if (note_r[32])
          check("rdata", cfg_rdata_o, note_r[31:0]);
      end
    end
  end
  // ---------------------------
  // main sequence
  // ---------------------------
  initial begin
    seed_r = lfsr(seed_r);
    load_mask(seed_r[15:0]);
    load_mask(16'hFFFF);
    load_mask(16'h0000);
    $display("mask load test done");
    seed_r = lfsr(seed_r);
    acc(0, 8'h6C, {16'h0000, seed_r[31:16]});
    acc(1, 8'h6C, {16'h0000, seed_r[31:16]});
    idle;
    drain;
    clk_chk(seed_r[31:16]);
    $display("mask write test done");
    for (int k = 0; k < 7; k++) begin
      seed_r = lfsr(seed_r);
      ext_r <= seed_r[3:0];
      acc(0, 8'h64, wr_t[k]);
      idle;
      out_e = (out_e | wr_t[k][3:0]) & ~wr_t[k][11:8];
      oe_e = (oe_e | wr_t[k][19:16]) & ~wr_t[k][27:24];
      repeat (4) @(negedge clk_sys_i);
      check("oe_n", gpio_oe_n_o ^ oe_e, 4'hF);
      check("drive", ~gpio_oe_n_o & pin_w, oe_e & out_e);
      acc(1, 8'h64, {4'h0, oe_e, 4'h0, oe_e, 4'h0, out_e, 4'h0, out_e});
      acc(1, 8'h68, {28'h0, (oe_e & out_e) | (~oe_e & ext_r)});
      idle;
      drain;
    end
    $display("gpio test done");
    acc(0, 8'h04, 32'h00000007);
    acc(0, 8'h40, 32'h00000001);
    idle;
    ext_r <= 4'h8;
    repeat (8) @(negedge clk_sys_i);
    check("halt", {forward_halt_o, io_en_o, mem_en_o, master_en_o}, 4'h8);
    acc(1, 8'h04, 32'h00000007);
    acc(1, 8'h80, 32'h00000000);
    idle;
    drain;
    ext_r <= 4'h0;
    repeat (8) @(negedge clk_sys_i);
    check("resume", {forward_halt_o, io_en_o, mem_en_o, master_en_o}, 4'h7);
    acc(0, 8'h64, 32'h00080000);
    idle;
    ext_r <= 4'h8;
    repeat (8) @(negedge clk_sys_i);
    check("no_halt", {forward_halt_o, io_en_o, mem_en_o, master_en_o}, 4'h7);
    drain;
    $display("live insertion test done");
    // secondary reset bit holds and releases the secondary reset
    acc(0, 8'h3C, 32'h00400000);
    acc(1, 8'h3C, 32'h00400000);
    idle;
    drain;
    repeat (4) @(negedge clk_sys_i);
    check("srst_set", secondary_reset_n_o, 0);
    acc(0, 8'h3C, 32'h00000000);
    idle;
    drain;
    repeat (4) @(negedge clk_sys_i);
    check("srst_clr", secondary_reset_n_o, 1);
    $display("reset bit test done");
    finish_test();
  end
endmodule // gcm_gpio_tb
